// ==== rtl/reset_and_power_state_control.sv ====
// reset and power-state sequencer: combines reset sources, times holds, tracks power states
// assumes all inputs except rst_b synchronous to clk; set inputs are one-cycle pulses from the register block
`timescale 1ns/1ns
`default_nettype none
module reset_and_power_state_control
  import rstpwr_pkg::*;
#(
  parameter int PORHOLDCYC  = POR_HOLD_CYC,
  parameter int DETACHUNIT  = DETACH_UNIT_CYC,
  parameter int PHYRSTCYC   = ETH_PHY_RESET_BIT_CYC,
  parameter int PHYANACYC   = PHY_ANA_CYC,
  parameter int PHYFASTCYC  = PHY_FAST_CYC
) (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic [NUM_SUPPLIES-1:0] supplyBelowFall,
  input  wire logic [NUM_SUPPLIES-1:0] supplyAboveRise,
  input  wire logic                    extReset_b,
  input  wire logic                    bus_power_detect,
  input  wire logic                    pllLocked,
  input  wire logic                    usbBusReset,
  input  wire logic                    liteResetSet,
  input  wire logic                    softResetSet,
  input  wire logic                    ethPhyResetSet,
  input  wire logic [7:0]              detach_duration_field,
  input  wire logic                    skip_analog_ref_wait,
  input  wire logic                    cfgPresent,
  input  wire logic                    cfgLoadDone,
  input  wire logic                    setConfig,
  input  wire logic                    clearConfig,
  input  wire logic                    suspendReq,
  input  wire logic                    suspendLowestSel,
  input  wire logic                    resumeSignal,
  input  wire logic                    wakeEvent,
  output logic                         lite_reset_bit,
  output logic                         soft_reset_bit,
  output logic                         eth_phy_reset_bit,
  output rst_out_t                     rstOut,
  output clk_ctl_t                     clkCtl,
  output logic                         cfgLoadReq,
  output logic                         cfgLoadMacOnly,
  output logic                         usbDetach,
  output logic                         ready,
  output pwr_t                         powerState,
  output logic                         lowest_power_suspend
);

  // ---------------------------------------------------------------
  // reset deassertion synchroniser
  // ---------------------------------------------------------------
  logic rstMeta;
  logic rstSync;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // ---------------------------------------------------------------
  // supply detectors with hysteresis
  // ---------------------------------------------------------------
  logic [NUM_SUPPLIES-1:0] supplyLow;
  logic [NUM_SUPPLIES-1:0] next_supplyLow;

  always_comb begin
    for (int i = 0; i < NUM_SUPPLIES; i++) begin
      if (supplyBelowFall[i]) begin
        next_supplyLow[i] = 1'b1;
      end else if (supplyAboveRise[i]) begin
        next_supplyLow[i] = 1'b0;
      end else begin
        next_supplyLow[i] = supplyLow[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      supplyLow <= {NUM_SUPPLIES{1'b1}};
    end else if (!rstSync) begin
      supplyLow <= {NUM_SUPPLIES{1'b1}};
    end else begin
      supplyLow <= next_supplyLow;
    end
  end

  logic porActive;
  assign porActive = |supplyLow;

  // ---------------------------------------------------------------
  // reset sequencer
  // ---------------------------------------------------------------
  seq_t             seqState;
  seq_t             next_seqState;
  logic [TMR_W-1:0] seqTimer;
  logic [TMR_W-1:0] next_seqTimer;
  logic             next_lite;
  logic             next_soft;
  logic             corePulse;
  logic             next_corePulse;
  logic             litePulse;
  logic             next_litePulse;
  logic             next_cfgLoadReq;
  logic             next_cfgLoadMacOnly;
  logic             holdCause;
  pwr_t             pwrState;

  assign holdCause = porActive || !extReset_b || (pwrState == PWR_NO_BUS);

  always_comb begin
    next_seqState       = seqState;
    next_seqTimer       = seqTimer;
    next_lite           = lite_reset_bit | liteResetSet;
    next_soft           = soft_reset_bit | softResetSet;
    next_corePulse      = 1'b0;
    next_litePulse      = 1'b0;
    next_cfgLoadReq     = 1'b0;
    next_cfgLoadMacOnly = cfgLoadMacOnly;
    if (porActive) begin
      next_seqState = SEQ_HOLD;
      next_seqTimer = TMR_W'(PORHOLDCYC);
    end else if (holdCause) begin
      next_seqState = SEQ_HOLD;
    end else begin
      case (seqState)
        SEQ_HOLD: begin
          if (seqTimer != TMR_ZERO) begin
            next_seqTimer = seqTimer - TMR_ONE;
          end else if (cfgPresent) begin
            next_seqState       = SEQ_LOAD;
            next_cfgLoadReq     = 1'b1;
            next_cfgLoadMacOnly = 1'b0;
          end else begin
            next_seqState = SEQ_RUN;
          end
        end
        SEQ_LOAD: begin
          if (usbBusReset) begin
            next_corePulse      = 1'b1;
            next_cfgLoadReq     = 1'b1;
            next_cfgLoadMacOnly = 1'b1;
          end else if (cfgLoadDone) begin
            next_seqState = SEQ_RUN;
          end
        end
        SEQ_RUN: begin
          if (soft_reset_bit) begin
            next_seqState = SEQ_DETACH;
            next_seqTimer = TMR_W'(TMR_W'(detach_duration_field) * TMR_W'(DETACHUNIT));
            next_soft     = softResetSet;
          end else if (usbBusReset) begin
            next_corePulse      = 1'b1;
            next_cfgLoadReq     = cfgPresent;
            next_cfgLoadMacOnly = 1'b1;
            next_seqState       = cfgPresent ? SEQ_LOAD : SEQ_RUN;
          end else if (lite_reset_bit) begin
            next_corePulse = 1'b1;
            next_litePulse = 1'b1;
            next_lite      = liteResetSet;
          end
        end
        SEQ_DETACH: begin
          if (seqTimer != TMR_ZERO) begin
            next_seqTimer = seqTimer - TMR_ONE;
          end else begin
            next_seqState = SEQ_HOLD;
          end
        end
        default: begin
          next_seqState = SEQ_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seqState       <= SEQ_HOLD;
      seqTimer       <= TMR_ZERO;
      lite_reset_bit <= 1'b0;
      soft_reset_bit <= 1'b0;
      corePulse      <= 1'b0;
      litePulse      <= 1'b0;
      cfgLoadReq     <= 1'b0;
      cfgLoadMacOnly <= 1'b0;
    end else if (!rstSync) begin
      seqState       <= SEQ_HOLD;
      seqTimer       <= TMR_ZERO;
      lite_reset_bit <= 1'b0;
      soft_reset_bit <= 1'b0;
      corePulse      <= 1'b0;
      litePulse      <= 1'b0;
      cfgLoadReq     <= 1'b0;
      cfgLoadMacOnly <= 1'b0;
    end else begin
      seqState       <= next_seqState;
      seqTimer       <= next_seqTimer;
      lite_reset_bit <= next_lite;
      soft_reset_bit <= next_soft;
      corePulse      <= next_corePulse;
      litePulse      <= next_litePulse;
      cfgLoadReq     <= next_cfgLoadReq;
      cfgLoadMacOnly <= next_cfgLoadMacOnly;
    end
  end

  // ---------------------------------------------------------------
  // power state
  // ---------------------------------------------------------------
  pwr_t pwrNext;
  logic fromUnconf;
  logic next_fromUnconf;
  logic lowestSel;
  logic next_lowestSel;
  logic chipHold;

  assign chipHold = (seqState == SEQ_HOLD);

  always_comb begin
    pwrNext         = pwrState;
    next_fromUnconf = fromUnconf;
    next_lowestSel  = lowestSel;
    if (!bus_power_detect) begin
      pwrNext = PWR_NO_BUS;
    end else begin
      case (pwrState)
        PWR_NO_BUS: begin
          pwrNext = PWR_PLLWAIT;
        end
        PWR_PLLWAIT: begin
          if (pllLocked) begin
            pwrNext = PWR_UNCONF;
          end
        end
        PWR_UNCONF: begin
          if (chipHold) begin
            pwrNext = PWR_UNCONF;
          end else if (setConfig) begin
            pwrNext = PWR_CONF;
          end else if (suspendReq) begin
            pwrNext         = PWR_SUSPEND;
            next_fromUnconf = 1'b1;
            next_lowestSel  = 1'b1;
          end
        end
        PWR_CONF: begin
          if (chipHold || usbBusReset) begin
            pwrNext = PWR_UNCONF;
          end else if (clearConfig) begin
            pwrNext = PWR_UNCONF;
          end else if (suspendReq) begin
            pwrNext         = PWR_SUSPEND;
            next_fromUnconf = 1'b0;
            next_lowestSel  = suspendLowestSel;
          end
        end
        PWR_SUSPEND: begin
          if (chipHold || usbBusReset) begin
            pwrNext = PWR_UNCONF;
          end else if (resumeSignal || wakeEvent) begin
            pwrNext = fromUnconf ? PWR_UNCONF : PWR_CONF;
          end
        end
        default: begin
          pwrNext = PWR_NO_BUS;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwrState   <= PWR_NO_BUS;
      fromUnconf <= 1'b0;
      lowestSel  <= 1'b0;
    end else if (!rstSync) begin
      pwrState   <= PWR_NO_BUS;
      fromUnconf <= 1'b0;
      lowestSel  <= 1'b0;
    end else begin
      pwrState   <= pwrNext;
      fromUnconf <= next_fromUnconf;
      lowestSel  <= next_lowestSel;
    end
  end

  // ---------------------------------------------------------------
  // ethernet phy reset and bring-up
  // ---------------------------------------------------------------
  phy_t             phyState;
  phy_t             next_phyState;
  logic [TMR_W-1:0] phyTimer;
  logic [TMR_W-1:0] next_phyTimer;
  logic             next_phyBit;

  always_comb begin
    next_phyState = phyState;
    next_phyTimer = phyTimer;
    next_phyBit   = eth_phy_reset_bit | ethPhyResetSet;
    if (pwrState != PWR_CONF && pwrState != PWR_SUSPEND) begin
      next_phyState = PHY_OFF;
    end else begin
      case (phyState)
        PHY_OFF: begin
          if (pwrState == PWR_CONF) begin
            next_phyState = ETH_PHY_RESET_BIT;
            next_phyTimer = TMR_W'(PHYRSTCYC);
          end
        end
        ETH_PHY_RESET_BIT: begin
          if (phyTimer > TMR_ONE) begin
            next_phyTimer = phyTimer - TMR_ONE;
          end else begin
            next_phyState = PHY_WAIT;
            next_phyTimer = skip_analog_ref_wait ? TMR_W'(PHYFASTCYC) : TMR_W'(PHYANACYC);
          end
        end
        PHY_WAIT: begin
          if (phyTimer > TMR_ONE) begin
            next_phyTimer = phyTimer - TMR_ONE;
          end else begin
            next_phyState = PHY_UP;
          end
        end
        PHY_UP: begin
          next_phyState = PHY_UP;
        end
        default: begin
          next_phyState = PHY_OFF;
        end
      endcase
      if (eth_phy_reset_bit && pwrState == PWR_CONF) begin
        next_phyState = ETH_PHY_RESET_BIT;
        next_phyTimer = TMR_W'(PHYRSTCYC);
        next_phyBit   = ethPhyResetSet;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phyState          <= PHY_OFF;
      phyTimer          <= TMR_ZERO;
      eth_phy_reset_bit <= 1'b0;
    end else if (!rstSync || chipHold || corePulse) begin
      phyState          <= PHY_OFF;
      phyTimer          <= TMR_ZERO;
      eth_phy_reset_bit <= 1'b0;
    end else begin
      phyState          <= next_phyState;
      phyTimer          <= next_phyTimer;
      eth_phy_reset_bit <= next_phyBit;
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  rst_out_t next_rstOut;
  clk_ctl_t next_clkCtl;
  logic     next_ready;
  logic     next_detach;
  logic     pllRun;

  assign pllRun = (pwrState == PWR_PLLWAIT) || (pwrState == PWR_UNCONF) || (pwrState == PWR_CONF)
                  || (pwrState == PWR_SUSPEND && !lowestSel);

  always_comb begin
    next_rstOut.chip       = chipHold;
    next_rstOut.core       = chipHold || corePulse;
    next_rstOut.ethPhy     = chipHold || corePulse || phyState == PHY_OFF || phyState == ETH_PHY_RESET_BIT;
    next_rstOut.keepExempt = litePulse;
    next_clkCtl.osc        = (pwrState != PWR_NO_BUS);
    next_clkCtl.pll        = pllRun;
    next_clkCtl.derived    = pllRun && pllLocked;
    next_ready             = (seqState == SEQ_RUN) && !corePulse
                             && (pwrState == PWR_UNCONF || (pwrState == PWR_CONF && phyState == PHY_UP));
    next_detach            = (seqState == SEQ_DETACH);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstOut               <= '{chip: 1'b1, core: 1'b1, ethPhy: 1'b1, keepExempt: 1'b0};
      clkCtl               <= '{osc: 1'b0, pll: 1'b0, derived: 1'b0};
      ready                <= 1'b0;
      usbDetach            <= 1'b0;
      powerState           <= PWR_NO_BUS;
      lowest_power_suspend <= 1'b0;
    end else begin
      rstOut               <= next_rstOut;
      clkCtl               <= next_clkCtl;
      ready                <= next_ready;
      usbDetach            <= next_detach;
      powerState           <= pwrState;
      lowest_power_suspend <= (pwrState == PWR_SUSPEND) && lowestSel;
    end
  end

endmodule : reset_and_power_state_control
`default_nettype wire

// ==== common/rstpwr_pkg.sv ====
// constants, states and carrier types for the reset and power-state sequencer
// assumes one 10 MHz always-on clock; times below are converted to cycles here
package rstpwr_pkg;
  localparam int CLK_HZ        = 10_000_000;
  localparam int POR_HOLD_MS   = 20;
  localparam int DETACH_UNIT_MS = 1;
  localparam int ETH_PHY_RESET_BIT_MS    = 2;
  localparam int PHY_ANA_MS    = 100;
  localparam int PHY_FAST_MS   = 1;
  localparam int POR_HOLD_CYC  = POR_HOLD_MS * (CLK_HZ / 1000);
  localparam int DETACH_UNIT_CYC = DETACH_UNIT_MS * (CLK_HZ / 1000);
  localparam int ETH_PHY_RESET_BIT_CYC   = ETH_PHY_RESET_BIT_MS * (CLK_HZ / 1000);
  localparam int PHY_ANA_CYC   = PHY_ANA_MS * (CLK_HZ / 1000);
  localparam int PHY_FAST_CYC  = PHY_FAST_MS * (CLK_HZ / 1000);
  localparam int NUM_SUPPLIES  = 5;
  localparam int TMR_W         = 24;
  localparam logic [TMR_W-1:0] TMR_ZERO = 24'h000000;
  localparam logic [TMR_W-1:0] TMR_ONE  = 24'h000001;

  typedef enum logic [1:0] {
    SEQ_HOLD   = 2'b00,
    SEQ_LOAD   = 2'b01,
    SEQ_RUN    = 2'b10,
    SEQ_DETACH = 2'b11
  } seq_t;

  typedef enum logic [2:0] {
    PWR_NO_BUS  = 3'b000,
    PWR_PLLWAIT = 3'b001,
    PWR_UNCONF  = 3'b010,
    PWR_CONF    = 3'b011,
    PWR_SUSPEND = 3'b100
  } pwr_t;

  typedef enum logic [1:0] {
    PHY_OFF  = 2'b00,
    ETH_PHY_RESET_BIT  = 2'b01,
    PHY_WAIT = 2'b10,
    PHY_UP   = 2'b11
  } phy_t;

  typedef struct packed {
    logic chip;
    logic core;
    logic ethPhy;
    logic keepExempt;
  } rst_out_t;

  typedef struct packed {
    logic osc;
    logic pll;
    logic derived;
  } clk_ctl_t;
endpackage : rstpwr_pkg

// ==== tb/usb_host_model.sv ====
// behavioural host and driver: issues one-cycle requests toward the sequencer
// assumes the bench calls send from its main sequence only
`timescale 1ns/1ns
`default_nettype none
module usb_host_model
  import rstpwr_pkg::*;
(
  input  wire logic clk,
  output logic      usbBusReset,
  output logic      liteResetSet,
  output logic      softResetSet,
  output logic      ethPhyResetSet,
  output logic      setConfig,
  output logic      clearConfig,
  output logic      suspendReq,
  output logic      resumeSignal
);
  logic [7:0] req = 8'h00;
  logic       pipesRun = 1'b1;

  assign {usbBusReset, liteResetSet, softResetSet, ethPhyResetSet} = req[7:4];
  assign {setConfig, clearConfig, suspendReq, resumeSignal} = req[3:0];

  task send(input logic [7:0] r);
    @(posedge clk);
    if (r[6]) pipesRun <= 1'b0;
    req <= r;
    @(posedge clk);
    req <= 8'h00;
    if (r[6]) pipesRun <= 1'b1;
  endtask : send
endmodule : usb_host_model
`default_nettype wire

// ==== tb/rstpwr_assertions.sv ====
// concurrent checks on the sequencer ports
// assumes the bind hands on the instance parameters
`timescale 1ns/1ns
`default_nettype none
module rstpwr_assertions
  import rstpwr_pkg::*;
#(
  parameter int DETACHUNIT = DETACH_UNIT_CYC,
  parameter int PHYRSTCYC  = ETH_PHY_RESET_BIT_CYC,
  parameter int PHYANACYC  = PHY_ANA_CYC,
  parameter int PHYFASTCYC = PHY_FAST_CYC
) (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       bus_power_detect,
  input wire logic       cfgLoadDone,
  input wire logic [7:0] detach_duration_field,
  input wire logic       skip_analog_ref_wait,
  input wire logic       soft_reset_bit,
  input wire rst_out_t   rstOut,
  input wire clk_ctl_t   clkCtl,
  input wire logic       cfgLoadReq,
  input wire logic       cfgLoadMacOnly,
  input wire logic       usbDetach,
  input wire logic       ready,
  input wire pwr_t       powerState
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  int   detCnt, phyCnt, relCnt, next_detCnt, next_phyCnt, next_relCnt;
  logic pend, next_pend;

  always_comb begin
    next_detCnt = usbDetach ? detCnt + 1 : 0;
    next_phyCnt = rstOut.ethPhy ? phyCnt + 1 : 0;
    next_relCnt = rstOut.ethPhy ? 0 : relCnt + 1;
    next_pend   = cfgLoadReq ? 1'b1 : (cfgLoadDone ? 1'b0 : pend);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      detCnt <= 0;
      phyCnt <= 0;
      relCnt <= 0;
      pend   <= 1'b0;
    end else begin
      detCnt <= next_detCnt;
      phyCnt <= next_phyCnt;
      relCnt <= next_relCnt;
      pend   <= next_pend;
    end
  end

  sequence s_detach_start;
    !soft_reset_bit ##1 usbDetach;
  endsequence
  sequence s_core_pulse;
    rstOut.core && !rstOut.chip;
  endsequence

  property p_nobus; !bus_power_detect [*2] |=> powerState == PWR_NO_BUS; endproperty
  a_nobus: assert property (p_nobus) else $error("no bus-power state not entered");
  property p_nobus_chip; (powerState == PWR_NO_BUS) [*3] |-> rstOut.chip; endproperty
  a_nobus_chip: assert property (p_nobus_chip) else $error("chip not held without bus power");
  property p_nobus_clk; (powerState == PWR_NO_BUS) [*2] |-> !clkCtl.osc && !clkCtl.pll; endproperty
  a_nobus_clk: assert property (p_nobus_clk) else $error("clocks on without bus power");
  property p_unconf_phy; (powerState == PWR_UNCONF) [*2] |-> rstOut.ethPhy; endproperty
  a_unconf_phy: assert property (p_unconf_phy) else $error("phy released while unconfigured");
  property p_soft_seq;
    $rose(soft_reset_bit) && ready && powerState == PWR_UNCONF |=> s_detach_start;
  endproperty
  a_soft_seq: assert property (p_soft_seq) else $error("soft reset bit or detach wrong");
  property p_detach_len;
    $fell(usbDetach) |-> detCnt >= detach_duration_field * DETACHUNIT
      && detCnt <= detach_duration_field * DETACHUNIT + 2;
  endproperty
  a_detach_len: assert property (p_detach_len) else $error("detach length wrong");
  property p_detach_reset; $fell(usbDetach) |-> ##[0:3] rstOut.chip; endproperty
  a_detach_reset: assert property (p_detach_reset) else $error("no chip reset after detach");
  property p_lite; rstOut.keepExempt |-> rstOut.core && !rstOut.chip; endproperty
  a_lite: assert property (p_lite) else $error("lite reset reached chip");
  property p_usbrst; $rose(cfgLoadReq) && cfgLoadMacOnly |=> s_core_pulse; endproperty
  a_usbrst: assert property (p_usbrst) else $error("bus reset core pulse missing");
  property p_ready_pending; pend && $past(pend) |-> !ready; endproperty
  a_ready_pending: assert property (p_ready_pending) else $error("ready during load");
  property p_phy_hold; $fell(rstOut.ethPhy) && powerState == PWR_CONF |-> phyCnt >= PHYRSTCYC; endproperty
  a_phy_hold: assert property (p_phy_hold) else $error("phy reset too short");
  property p_phy_wait;
    $rose(ready) && powerState == PWR_CONF |-> relCnt >= (skip_analog_ref_wait ? PHYFASTCYC : PHYANACYC);
  endproperty
  a_phy_wait: assert property (p_phy_wait) else $error("ready before phy up");
endmodule : rstpwr_assertions

bind reset_and_power_state_control rstpwr_assertions #(.DETACHUNIT(DETACHUNIT), .PHYRSTCYC(PHYRSTCYC),
  .PHYANACYC(PHYANACYC), .PHYFASTCYC(PHYFASTCYC)) i_chk (.clk(clk), .rst_b(rst_b),
  .bus_power_detect(bus_power_detect), .cfgLoadDone(cfgLoadDone), .detach_duration_field(detach_duration_field),
  .skip_analog_ref_wait(skip_analog_ref_wait), .soft_reset_bit(soft_reset_bit), .rstOut(rstOut),
  .clkCtl(clkCtl), .cfgLoadReq(cfgLoadReq), .cfgLoadMacOnly(cfgLoadMacOnly), .usbDetach(usbDetach),
  .ready(ready), .powerState(powerState));
`default_nettype wire

// ==== tb/reset_and_power_state_control_bench.sv ====
// self-checking bench for the sequencer with a host model on the far side
// assumes shortened hold parameters; inputs change at the rising edge, checks at the falling edge
`timescale 1ns/1ns
`default_nettype none
module reset_and_power_state_control_bench
  import rstpwr_pkg::*;
;
  localparam int T_POR = 20, T_DU = 4, T_PHY = 5, T_ANA = 10, T_FAST = 3;
  localparam logic [7:0] BUSRST = 8'h80, LITE = 8'h40, SOFT = 8'h20, PHYR = 8'h10;
  localparam logic [7:0] SETC = 8'h08, CLRC = 8'h04, SUSP = 8'h02, RESUME = 8'h01;
  logic clk = 1'b0, rst_b = 1'b0, extReset_b = 1'b1, bus_power_detect = 1'b0, pllLocked = 1'b0;
  logic cfgLoadDone = 1'b0, skip_analog_ref_wait = 1'b0, suspendLowestSel = 1'b0, wakeEvent = 1'b0;
  logic [4:0] supplyBelowFall = 5'h00, supplyAboveRise = 5'h1f;
  logic [7:0] detach_duration_field = 8'h02;
  logic usbBusReset, liteResetSet, softResetSet, ethPhyResetSet, setConfig, clearConfig, suspendReq, resumeSignal;
  logic lite_reset_bit, soft_reset_bit, eth_phy_reset_bit, cfgLoadReq, cfgLoadMacOnly, usbDetach, ready;
  logic lowest_power_suspend;
  rst_out_t rstOut;
  clk_ctl_t clkCtl;
  pwr_t     powerState;
  int bad_count = 0, n_checks = 0, cycles = 0, n;

  usb_host_model i_host (.clk(clk), .usbBusReset(usbBusReset), .liteResetSet(liteResetSet),
    .softResetSet(softResetSet), .ethPhyResetSet(ethPhyResetSet), .setConfig(setConfig),
    .clearConfig(clearConfig), .suspendReq(suspendReq), .resumeSignal(resumeSignal));

  reset_and_power_state_control #(.PORHOLDCYC(T_POR), .DETACHUNIT(T_DU), .PHYRSTCYC(T_PHY),
    .PHYANACYC(T_ANA), .PHYFASTCYC(T_FAST)) i_dut (.clk(clk), .rst_b(rst_b),
    .supplyBelowFall(supplyBelowFall), .supplyAboveRise(supplyAboveRise), .extReset_b(extReset_b),
    .bus_power_detect(bus_power_detect), .pllLocked(pllLocked), .usbBusReset(usbBusReset),
    .liteResetSet(liteResetSet), .softResetSet(softResetSet), .ethPhyResetSet(ethPhyResetSet),
    .detach_duration_field(detach_duration_field), .skip_analog_ref_wait(skip_analog_ref_wait),
    .cfgPresent(1'b1), .cfgLoadDone(cfgLoadDone), .setConfig(setConfig), .clearConfig(clearConfig),
    .suspendReq(suspendReq), .suspendLowestSel(suspendLowestSel), .resumeSignal(resumeSignal),
    .wakeEvent(wakeEvent), .lite_reset_bit(lite_reset_bit), .soft_reset_bit(soft_reset_bit),
    .eth_phy_reset_bit(eth_phy_reset_bit), .rstOut(rstOut), .clkCtl(clkCtl), .cfgLoadReq(cfgLoadReq),
    .cfgLoadMacOnly(cfgLoadMacOnly), .usbDetach(usbDetach), .ready(ready), .powerState(powerState),
    .lowest_power_suspend(lowest_power_suspend));

  initial begin
    forever #50 clk = ~clk;
  end

  task conclude;
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  task check(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task checkState(input pwr_t got, input pwr_t exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : checkState

  task waitState(input pwr_t s);
    repeat (300) if (powerState !== s) @(negedge clk);
    checkState(powerState, s);
  endtask : waitState

  // waits for a load request, answers it and expects ready afterwards
  task loadCfg(input logic macOnly);
    repeat (300) if (cfgLoadReq !== 1'b1) @(negedge clk);
    check(cfgLoadReq, 1'b1);
    check(cfgLoadMacOnly, macOnly);
    @(negedge clk);
    check(rstOut.chip, 1'b0);
    check(ready, 1'b0);
    @(posedge clk) cfgLoadDone <= 1'b1;
    @(posedge clk) cfgLoadDone <= 1'b0;
    repeat (100) if (ready !== 1'b1) @(negedge clk);
    check(ready, 1'b1);
  endtask : loadCfg

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (5) @(negedge clk);
    checkState(powerState, PWR_NO_BUS);
    check(rstOut.chip, 1'b1);
    check(clkCtl.pll, 1'b0);
    @(posedge clk) bus_power_detect <= 1'b1;
    waitState(PWR_PLLWAIT);
    @(posedge clk) pllLocked <= 1'b1;
    waitState(PWR_UNCONF);
    check(rstOut.ethPhy, 1'b1);
    loadCfg(1'b0);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      supplyBelowFall[i] <= 1'b1;
      supplyAboveRise[i] <= 1'b0;
      @(posedge clk) supplyBelowFall[i] <= 1'b0;
      repeat (30) @(negedge clk);
      check(rstOut.chip, 1'b1);
      @(posedge clk) supplyAboveRise[i] <= 1'b1;
      n = 0;
      @(negedge clk);
      while (rstOut.chip === 1'b1 && cfgLoadReq !== 1'b1 && n < 100) begin
        n++;
        @(negedge clk);
      end
      check(n >= T_POR && n <= T_POR + 4, 1'b1);
      loadCfg(1'b0);
    end
    @(posedge clk) extReset_b <= 1'b0;
    repeat (4) @(negedge clk);
    check(rstOut.chip, 1'b1);
    @(posedge clk) extReset_b <= 1'b1;
    loadCfg(1'b0);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) skip_analog_ref_wait <= k[0];
      i_host.send(SETC);
      waitState(PWR_CONF);
      repeat (100) if (ready !== 1'b1) @(negedge clk);
      i_host.send(PHYR);
      repeat (6) if (ready !== 1'b0) @(negedge clk);
      check(rstOut.ethPhy, 1'b1);
      check(rstOut.chip, 1'b0);
      n = 0;
      while (ready !== 1'b1 && n < 100) begin
        n++;
        @(negedge clk);
      end
      n = n - T_PHY - (k ? T_FAST : T_ANA);
      check(n >= -2 && n <= 4, 1'b1);
      i_host.send(CLRC);
      waitState(PWR_UNCONF);
      @(negedge clk);
      check(rstOut.ethPhy, 1'b1);
    end
    i_host.send(SETC);
    waitState(PWR_CONF);
    repeat (100) if (ready !== 1'b1) @(negedge clk);
    i_host.send(LITE);
    repeat (6) if (rstOut.core !== 1'b1) @(negedge clk);
    check(rstOut.keepExempt, 1'b1);
    check(rstOut.chip, 1'b0);
    check(clkCtl.pll, 1'b1);
    checkState(powerState, PWR_CONF);
    i_host.send(BUSRST);
    loadCfg(1'b1);
    waitState(PWR_UNCONF);
    i_host.send(SOFT);
    repeat (6) if (usbDetach !== 1'b1) @(negedge clk);
    check(soft_reset_bit, 1'b0);
    n = 0;
    while (usbDetach === 1'b1 && n < 100) begin
      n++;
      @(negedge clk);
    end
    check(n >= 2 * T_DU && n <= 2 * T_DU + 2, 1'b1);
    repeat (4) if (rstOut.chip !== 1'b1) @(negedge clk);
    check(rstOut.chip, 1'b1);
    loadCfg(1'b0);
    @(posedge clk) suspendLowestSel <= 1'b0;
    i_host.send(SUSP);
    waitState(PWR_SUSPEND);
    @(negedge clk);
    check(lowest_power_suspend, 1'b1);
    check(clkCtl.osc, 1'b1);
    i_host.send(RESUME);
    waitState(PWR_UNCONF);
    @(posedge clk) suspendLowestSel <= 1'b1;
    i_host.send(SETC);
    waitState(PWR_CONF);
    i_host.send(SUSP);
    waitState(PWR_SUSPEND);
    check(clkCtl.pll, 1'b0);
    check(clkCtl.osc, 1'b1);
    @(posedge clk) wakeEvent <= 1'b1;
    @(posedge clk) wakeEvent <= 1'b0;
    waitState(PWR_CONF);
    @(posedge clk) bus_power_detect <= 1'b0;
    waitState(PWR_NO_BUS);
    repeat (3) @(negedge clk);
    check(rstOut.chip, 1'b1);
    check(clkCtl.pll, 1'b0);
    conclude();
  end
endmodule : reset_and_power_state_control_bench
`default_nettype wire
